// ### include/pts_pkg.sv
// Package: constants and types for the tap timing and auto-sleep block
package pts_pkg;
   // ==========================================================
   // Register offsets and reset values
   localparam logic [7:0] PTS_LATENCY_OFFSET = 8'h27;
   localparam logic [7:0] PTS_WINDOW_OFFSET = 8'h28;
   localparam logic [7:0] PTS_INACTIVITY_OFFSET = 8'h29;
   localparam logic [7:0] PTS_LATENCY_RESET = 8'h00;
   localparam logic [7:0] PTS_WINDOW_RESET = 8'h00;
   localparam logic [7:0] PTS_INACTIVITY_RESET = 8'h00;

   // ==========================================================
   // Timing: every step is a whole number of 1.25 ms base units
   localparam int PTS_CLOCK_PERIOD_PS = 25000;
   localparam int PTS_BASE_UNIT_PS = 1250000000; // 1.25 ms in picoseconds
   localparam int PTS_BASE_UNIT_CYCLES = PTS_BASE_UNIT_PS / PTS_CLOCK_PERIOD_PS;
   localparam logic [9:0] PTS_INACT_UNITS = 10'h100;      // 320 ms
   localparam logic [9:0] PTS_INACT_SLOW_UNITS = 10'h200; // 640 ms
   localparam logic [2:0] PTS_RATE_SLOWEST = 3'h7;        // 1.56 Hz
   localparam logic [2:0] PTS_SLEEP_RATE_BASE = 3'h4;     // Sleep code 00 = 50 Hz

   // ==========================================================
   // Oversampling mode encodings
   localparam logic [1:0] PTS_MODE_NORMAL = 2'h0;
   localparam logic [1:0] PTS_MODE_LOW_NOISE = 2'h1;
   localparam logic [1:0] PTS_MODE_HIGH_RES = 2'h2;
   localparam logic [1:0] PTS_MODE_LOW_POWER = 2'h3;

   // ==========================================================
   // State machines, Gray coded along the usual path
   typedef enum logic [1:0] {
      PTS_TAP_IDLE = 2'b00,
      PTS_TAP_LATENCY = 2'b01,
      PTS_TAP_WINDOW = 2'b11,
      PTS_TAP_SECOND = 2'b10
   } pts_tap_state_e;

   typedef enum logic [1:0] {
      PTS_PWR_STANDBY = 2'b00,
      PTS_PWR_WAKE = 2'b01,
      PTS_PWR_SLEEP = 2'b11
   } pts_power_state_e;
endpackage

// ### design/pts_timing.sv
// Tap latency/window timing and auto-wake/sleep controller
//
// Contract
// - Latency after first pulse ignores further pulses
// - Latency equals count times rate/mode step
// - Filtered normal/low-noise latency steps per rate
// - Filtered high-res and low-power latency steps
// - Unfiltered latency steps are the smaller table
// - Second pulse must start inside window
// - Second pulse narrow; may end past window
// - Window equals count times rate/mode/filter step
// - Filtered window steps match filtered latency
// - Unfiltered window steps match unfiltered latency
// - Inactivity count switches wake rate to sleep
// - Inactivity step 320 ms, 640 ms at 1.56
// - Four event sources restart timer and wake
// - Sleep and data-ready events never restart/wake
// - Only enabled selected sources wake device
// - Functions keep running at sleep rate
// - Auto-sleep off: only standby and wake
// - Every wake/sleep transition may raise interrupt
// - Sleep rate codes 50/12.5/6.25/1.56 Hz
// - Sleep rate overrides system and block rate
// - Wake-source bit gates function's wake ability
// - Oversampling codes normal/lnlp/high_resolution_oversampling/lowpower
module pts_timing
   import pts_pkg::*;
#(
   parameter int BASE_UNIT_CYCLES = PTS_BASE_UNIT_CYCLES
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Register port
   input wire logic reg_write_enable,
   input wire logic [7:0] reg_address,
   input wire logic [7:0] reg_write_data,
   output logic [7:0] reg_read_data,
   // Configuration bits
   input wire logic active,
   input wire logic [2:0] wake_data_rate_select,
   input wire logic [1:0] sleep_sample_rate,
   input wire logic [1:0] wake_oversampling_mode,
   input wire logic [1:0] sleep_oversampling_mode,
   input wire logic auto_sleep_enable,
   input wire logic pulse_lowpass_enable,
   input wire logic double_pulse_enable,
   input wire logic [3:0] interrupt_enable,
   input wire logic [3:0] wake_source_enable,
   input wire logic sleep_interrupt_enable,
   // Event inputs: bit 0 transient, 1 orientation, 2 tap, 3 freefall/motion
   input wire logic [3:0] function_event,
   input wire logic data_ready_event,
   // Pulse detector handshakes
   input wire logic pulse_start,
   input wire logic pulse_valid_end,
   input wire logic pulse_too_long,
   // Results
   output logic single_pulse_event,
   output logic double_pulse_event,
   output logic sleeping,
   output logic sleep_transition_event,
   output logic [2:0] active_rate_select,
   output logic [1:0] active_oversampling_mode,
   output logic [1:0] tap_state_out
);

   // ==========================================================
   // Step size lookup in 1.25 ms units
   function automatic logic [9:0] step_units(input logic [2:0] rate, input logic [1:0] mode,
                                             input logic filtered);
      logic [9:0] units;
      units = 10'h001;
      if (filtered)
      begin
         // Filtered table: doubles per rate down to 50 Hz
         units = 10'h002 << rate;
         if (rate > 3'h4)
            units = 10'h020;
         case (mode)
            PTS_MODE_HIGH_RES: units = (rate == 3'h0) ? 10'h002 : 10'h004;
            PTS_MODE_LOW_NOISE: units = (rate > 3'h4) ? 10'h080 : units;
            PTS_MODE_LOW_POWER: units = (rate == 3'h5) ? 10'h080 :
                                        (rate > 3'h5) ? 10'h100 : units;
            default: units = units;
         endcase
      end
      else
      begin
         // Unfiltered table: smaller steps, fast rates share one unit
         units = (rate == 3'h0) ? 10'h001 : (10'h001 << (rate - 3'h1));
         if (rate > 3'h4)
            units = 10'h008;
         case (mode)
            PTS_MODE_HIGH_RES: units = 10'h001;
            PTS_MODE_LOW_NOISE: units = (rate > 3'h4) ? 10'h020 : units;
            PTS_MODE_LOW_POWER: units = (rate > 3'h4) ? 10'h040 : (10'h001 << rate);
            default: units = units;
         endcase
      end
      return units;
   endfunction

   // ==========================================================
   // Registers
   logic [7:0] pulse_latency_time;       // Latency count
   logic [7:0] second_pulse_span_window; // Window count
   logic [7:0] sleep_inactivity_count;   // Inactivity count

   // Software writes; latency must be set even for single taps
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         pulse_latency_time <= PTS_LATENCY_RESET;
         second_pulse_span_window <= PTS_WINDOW_RESET;
         sleep_inactivity_count <= PTS_INACTIVITY_RESET;
      end
      else if (reg_write_enable)
      begin
         case (reg_address)
            PTS_LATENCY_OFFSET: pulse_latency_time <= reg_write_data;
            PTS_WINDOW_OFFSET: second_pulse_span_window <= reg_write_data;
            PTS_INACTIVITY_OFFSET: sleep_inactivity_count <= reg_write_data;
            default: ; // Unmapped writes dropped
         endcase
      end
   end

   // Read data registered; unmapped addresses read zero
   always_ff @(posedge clock)
   begin
      if (reset)
         reg_read_data <= 8'h00;
      else
      begin
         case (reg_address)
            PTS_LATENCY_OFFSET: reg_read_data <= pulse_latency_time;
            PTS_WINDOW_OFFSET: reg_read_data <= second_pulse_span_window;
            PTS_INACTIVITY_OFFSET: reg_read_data <= sleep_inactivity_count;
            default: reg_read_data <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // Active rate and mode
   pts_power_state_e power_state, next_power_state;
   logic [2:0] rate_now;  // Rate driving the tap timer
   logic [1:0] mode_now;  // Oversampling driving the tap timer

   // Sleep rate overrides the system rate everywhere while asleep
   always_comb
   begin
      if (power_state == PTS_PWR_SLEEP)
      begin
         rate_now = PTS_SLEEP_RATE_BASE + {1'b0, sleep_sample_rate};
         mode_now = sleep_oversampling_mode;
      end
      else
      begin
         rate_now = wake_data_rate_select;
         mode_now = wake_oversampling_mode;
      end
   end

   // Rate and mode outputs registered for downstream blocks
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         active_rate_select <= 3'h0;
         active_oversampling_mode <= PTS_MODE_NORMAL;
      end
      else
      begin
         active_rate_select <= rate_now;
         active_oversampling_mode <= mode_now;
      end
   end

   // ==========================================================
   // Base unit divider: one-cycle tick every 1.25 ms
   logic [31:0] base_count; // Cycle counter
   logic base_tick;         // Unit enable pulse

   always_ff @(posedge clock)
   begin
      if (reset || !active)
      begin
         base_count <= 32'h0;
         base_tick <= 1'b0;
      end
      else if (base_count == 32'(BASE_UNIT_CYCLES - 1))
      begin
         base_count <= 32'h0;
         base_tick <= 1'b1;
      end
      else
      begin
         base_count <= base_count + 32'h1;
         base_tick <= 1'b0;
      end
   end

   // ==========================================================
   // Tap timing machine
   pts_tap_state_e tap_state, next_tap_state;
   logic [9:0] tap_units;     // Units elapsed in current step
   logic [7:0] tap_steps;     // Steps elapsed in current interval
   logic [9:0] tap_step_size; // Units per step now
   logic tap_step;            // Step boundary this cycle
   logic latency_done;        // Latency reached its count
   logic window_done;         // Window reached its count

   assign tap_step_size = step_units(rate_now, mode_now, pulse_lowpass_enable);
   assign tap_step = base_tick && (tap_units + 10'h1 >= tap_step_size);
   assign latency_done = (tap_steps == pulse_latency_time);
   assign window_done = (tap_steps == second_pulse_span_window);
   assign tap_state_out = tap_state;

   // Next state; pulses arriving in latency simply fall through
   always_comb
   begin
      next_tap_state = tap_state;
      case (tap_state)
         PTS_TAP_IDLE:
            if (pulse_valid_end)
               next_tap_state = PTS_TAP_LATENCY;
         PTS_TAP_LATENCY:
            if (latency_done)
               next_tap_state = double_pulse_enable ? PTS_TAP_WINDOW : PTS_TAP_IDLE;
         PTS_TAP_WINDOW:
            if (pulse_start)
               next_tap_state = PTS_TAP_SECOND;
            else if (window_done)
               next_tap_state = PTS_TAP_IDLE;
         PTS_TAP_SECOND:
            // Width checked only, not whether it ends inside window
            if (pulse_valid_end || pulse_too_long)
               next_tap_state = PTS_TAP_IDLE;
         default: next_tap_state = PTS_TAP_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clock)
   begin
      if (reset || !active)
         tap_state <= PTS_TAP_IDLE;
      else
         tap_state <= next_tap_state;
   end

   // Step counters restart on every state change
   always_ff @(posedge clock)
   begin
      if (reset || !active || next_tap_state != tap_state)
      begin
         tap_units <= 10'h0;
         tap_steps <= 8'h0;
      end
      else if (tap_step)
      begin
         tap_units <= 10'h0;
         tap_steps <= (tap_steps == 8'hff) ? tap_steps : tap_steps + 8'h1;
      end
      else if (base_tick)
         tap_units <= tap_units + 10'h1;
   end

   // Tap results, one-cycle pulses
   always_ff @(posedge clock)
   begin
      if (reset || !active)
      begin
         single_pulse_event <= 1'b0;
         double_pulse_event <= 1'b0;
      end
      else
      begin
         single_pulse_event <= (tap_state == PTS_TAP_IDLE) && pulse_valid_end;
         double_pulse_event <= (tap_state == PTS_TAP_SECOND) && pulse_valid_end;
      end
   end

   // ==========================================================
   // Auto-wake/sleep
   logic [3:0] keep_awake_hits; // Enabled events
   logic [3:0] wake_hits;       // Enabled and wake-selected events
   logic activity;              // Restarts inactivity timer
   logic wake_request;          // Leaves sleep
   logic [9:0] inact_units;     // Units in current step
   logic [7:0] inact_steps;     // Steps of inactivity
   logic [9:0] inact_step_size; // 320 ms or 640 ms
   logic inact_expired;         // Inactivity reached its count

   // Per-source gating; sleep-transition and data-ready never enter
   genvar src;
   generate
      for (src = 0; src < 4; src++)
      begin : g_source
         assign keep_awake_hits[src] = function_event[src] && interrupt_enable[src];
         assign wake_hits[src] = keep_awake_hits[src] && wake_source_enable[src];
      end
   endgenerate

   assign activity = |keep_awake_hits;
   assign wake_request = |wake_hits;
   assign inact_step_size = (wake_data_rate_select == PTS_RATE_SLOWEST) ?
                            PTS_INACT_SLOW_UNITS : PTS_INACT_UNITS;
   assign inact_expired = (inact_steps >= sleep_inactivity_count);
   assign sleeping = (power_state == PTS_PWR_SLEEP);

   // Power machine; without auto-sleep only standby and wake
   always_comb
   begin
      next_power_state = power_state;
      case (power_state)
         PTS_PWR_STANDBY:
            if (active)
               next_power_state = PTS_PWR_WAKE;
         PTS_PWR_WAKE:
            if (!active)
               next_power_state = PTS_PWR_STANDBY;
            else if (auto_sleep_enable && !activity && inact_expired)
               next_power_state = PTS_PWR_SLEEP;
         PTS_PWR_SLEEP:
            if (!active)
               next_power_state = PTS_PWR_STANDBY;
            else if (wake_request || !auto_sleep_enable)
               next_power_state = PTS_PWR_WAKE;
         default: next_power_state = PTS_PWR_STANDBY;
      endcase
   end

   // State register
   always_ff @(posedge clock)
   begin
      if (reset)
         power_state <= PTS_PWR_STANDBY;
      else
         power_state <= next_power_state;
   end

   // Inactivity timer counts only while awake, cleared by activity
   always_ff @(posedge clock)
   begin
      if (reset || power_state != PTS_PWR_WAKE || activity)
      begin
         inact_units <= 10'h0;
         inact_steps <= 8'h0;
      end
      else if (base_tick && (inact_units + 10'h1 >= inact_step_size))
      begin
         inact_units <= 10'h0;
         inact_steps <= (inact_steps == 8'hff) ? inact_steps : inact_steps + 8'h1;
      end
      else if (base_tick)
         inact_units <= inact_units + 10'h1;
   end

   // Transition pulse on each wake/sleep change
   always_ff @(posedge clock)
   begin
      if (reset)
         sleep_transition_event <= 1'b0;
      else
         sleep_transition_event <= sleep_interrupt_enable &&
            ((power_state == PTS_PWR_WAKE && next_power_state == PTS_PWR_SLEEP) ||
             (power_state == PTS_PWR_SLEEP && next_power_state == PTS_PWR_WAKE));
   end

   // ==========================================================
   // Assertions
   default clocking @(posedge clock); endclocking
   default disable iff (reset);

   property p_latency_ignores;
      tap_state == PTS_TAP_LATENCY && !latency_done && active |=> tap_state == PTS_TAP_LATENCY;
   endproperty
   a_latency_ignores: assert property (p_latency_ignores) else $error("latency left early");

   property p_single_from_idle;
      single_pulse_event |-> $past(tap_state) == PTS_TAP_IDLE && tap_state == PTS_TAP_LATENCY;
   endproperty
   a_single_from_idle: assert property (p_single_from_idle) else $error("single event misplaced");

   property p_window_needs_double;
      $rose(tap_state == PTS_TAP_WINDOW) |-> $past(double_pulse_enable) && $past(latency_done);
   endproperty
   a_window_needs_double: assert property (p_window_needs_double) else $error("window without double");

   property p_window_expires;
      tap_state == PTS_TAP_WINDOW && window_done && !pulse_start && active |=> tap_state == PTS_TAP_IDLE;
   endproperty
   a_window_expires: assert property (p_window_expires) else $error("window did not close");

   property p_double_from_second;
      double_pulse_event |-> $past(tap_state) == PTS_TAP_SECOND && $past(pulse_valid_end);
   endproperty
   a_double_from_second: assert property (p_double_from_second) else $error("double event misplaced");

   property p_no_auto_sleep;
      !auto_sleep_enable ##1 !auto_sleep_enable |-> !sleeping;
   endproperty
   a_no_auto_sleep: assert property (p_no_auto_sleep) else $error("slept with auto-sleep off");

   property p_sleep_after_count;
      $rose(sleeping) |-> $past(inact_steps) >= $past(sleep_inactivity_count) && !$past(activity);
   endproperty
   a_sleep_after_count: assert property (p_sleep_after_count) else $error("slept too early");

   property p_wake_on_source;
      sleeping && active && wake_request |=> !sleeping;
   endproperty
   a_wake_on_source: assert property (p_wake_on_source) else $error("wake source ignored");

   property p_transition_irq;
      active && $changed(sleeping) && $past(active) && $past(sleep_interrupt_enable) |-> sleep_transition_event;
   endproperty
   a_transition_irq: assert property (p_transition_irq) else $error("transition not flagged");

   property p_sleep_rate;
      sleeping ##1 sleeping |-> active_rate_select == PTS_SLEEP_RATE_BASE + {1'b0, $past(sleep_sample_rate)};
   endproperty
   a_sleep_rate: assert property (p_sleep_rate) else $error("sleep rate not applied");

endmodule // pts_timing

// ### verification/pts_timing_bench.sv
// Self-checking bench for the tap timing and auto-sleep block
module pts_timing_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import pts_pkg::*;
   // ==========================================================
   // Signals and instance
   localparam int BU = 4; // Short base unit keeps the run brief
   logic clock, reset, reg_write_enable, active, auto_sleep_enable, pulse_lowpass_enable;
   logic double_pulse_enable, sleep_interrupt_enable, data_ready_event;
   logic pulse_start, pulse_valid_end, pulse_too_long, single_pulse_event, double_pulse_event;
   logic sleeping, sleep_transition_event;
   logic [7:0] reg_address, reg_write_data, reg_read_data;
   logic [2:0] wake_data_rate_select, active_rate_select;
   logic [1:0] sleep_sample_rate, wake_oversampling_mode, sleep_oversampling_mode;
   logic [1:0] active_oversampling_mode, tap_state_out;
   logic [3:0] interrupt_enable, wake_source_enable, function_event;
   int n_mismatch = 0;
   int samples_checked = 0;
   pts_timing #(.BASE_UNIT_CYCLES(BU)) DUT (.clock, .reset, .reg_write_enable, .reg_address,
      .reg_write_data, .reg_read_data, .active, .wake_data_rate_select, .sleep_sample_rate,
      .wake_oversampling_mode, .sleep_oversampling_mode, .auto_sleep_enable, .pulse_lowpass_enable,
      .double_pulse_enable, .interrupt_enable, .wake_source_enable, .sleep_interrupt_enable,
      .function_event, .data_ready_event, .pulse_start, .pulse_valid_end, .pulse_too_long,
      .single_pulse_event, .double_pulse_event, .sleeping, .sleep_transition_event,
      .active_rate_select, .active_oversampling_mode, .tap_state_out);
   // ==========================================================
   // Shared tasks; all driving happens just after a falling edge
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_address = a;
      reg_write_data = d;
      reg_write_enable = 1'b1;
      tick(1);
      reg_write_enable = 1'b0;
   endtask
   // Read data is registered, so it is looked at one cycle on
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_address = a;
      tick(1);
      chk("reg_read_data", e, reg_read_data);
   endtask
   // One-cycle strobe: 0 end in limit, 1 start, 2 too long
   task automatic pulse_in(input int k);
      pulse_valid_end = (k == 0);
      pulse_start = (k == 1);
      pulse_too_long = (k == 2);
      tick(1);
      {pulse_valid_end, pulse_start, pulse_too_long} = 3'h0;
   endtask
   task automatic fev(input logic [3:0] v);
      function_event = v;
      tick(1);
      function_event = 4'h0;
   endtask
   // Counts cycles spent in one tap state, bounded
   task automatic stay(input logic [1:0] st, output int n);
      n = 0;
      while (tap_state_out === st && n < 5000)
      begin
         tick(1);
         n++;
      end
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_regs();
      rd(PTS_LATENCY_OFFSET, PTS_LATENCY_RESET);
      rd(PTS_WINDOW_OFFSET, PTS_WINDOW_RESET);
      rd(PTS_INACTIVITY_OFFSET, PTS_INACTIVITY_RESET);
      wr(PTS_WINDOW_OFFSET, 8'ha5);
      wr(PTS_INACTIVITY_OFFSET, 8'hff);
      wr(PTS_LATENCY_OFFSET, 8'h3c);
      wr(8'h2a, 8'h5a); // Unmapped place must swallow this
      rd(PTS_LATENCY_OFFSET, 8'h3c);
      rd(PTS_WINDOW_OFFSET, 8'ha5);
      rd(PTS_INACTIVITY_OFFSET, 8'hff);
      rd(8'h2a, 8'h00);
   endtask
   // Latency of two steps under one rate, mode and filter setting
   task automatic t_latency(input logic [2:0] r, input logic [1:0] m, input logic f, input int units);
      int n;
      int exp;
      wake_data_rate_select = r;
      wake_oversampling_mode = m;
      pulse_lowpass_enable = f;
      double_pulse_enable = 1'b0;
      exp = 2 * units * BU;
      wr(PTS_LATENCY_OFFSET, 8'h02);
      pulse_in(0);
      chk("single_pulse_event", 1'b1, single_pulse_event);
      chk("tap_state_out", PTS_TAP_LATENCY, tap_state_out);
      pulse_in(0);
      chk("single_in_latency", 1'b0, single_pulse_event);
      stay(PTS_TAP_LATENCY, n);
      // Free-running unit tick puts up to one unit of jitter on the start
      chk("latency_length", 1'b1, n + BU > exp && n <= exp);
      chk("tap_state_out", PTS_TAP_IDLE, tap_state_out);
   endtask
   task automatic t_double();
      int n;
      wake_data_rate_select = 3'h0;
      wake_oversampling_mode = PTS_MODE_NORMAL;
      pulse_lowpass_enable = 1'b1;
      double_pulse_enable = 1'b1;
      wr(PTS_LATENCY_OFFSET, 8'h00);
      wr(PTS_WINDOW_OFFSET, 8'h01);
      // Window left to expire with no second start
      pulse_in(0);
      stay(PTS_TAP_LATENCY, n);
      chk("tap_state_out", PTS_TAP_WINDOW, tap_state_out);
      stay(PTS_TAP_WINDOW, n);
      chk("window_length", 1'b1, n + 2 >= 2 * BU && n <= 2 * BU + 1);
      chk("tap_state_out", PTS_TAP_IDLE, tap_state_out);
      // Second start in time; its end may fall well past the window
      pulse_in(0);
      stay(PTS_TAP_LATENCY, n);
      pulse_in(1);
      chk("tap_state_out", PTS_TAP_SECOND, tap_state_out);
      tick(30);
      chk("tap_state_out", PTS_TAP_SECOND, tap_state_out);
      pulse_in(0);
      chk("double_pulse_event", 1'b1, double_pulse_event);
      // Second pulse too wide gives nothing
      pulse_in(0);
      stay(PTS_TAP_LATENCY, n);
      pulse_in(1);
      pulse_in(2);
      chk("double_pulse_event", 1'b0, double_pulse_event);
      chk("tap_state_out", PTS_TAP_IDLE, tap_state_out);
      double_pulse_enable = 1'b0;
   endtask
   task automatic t_sleep();
      int n;
      wake_data_rate_select = 3'h0;
      interrupt_enable = 4'hb; // Tap interrupt off at first
      wake_source_enable = 4'h4;
      sleep_sample_rate = 2'h2;
      sleep_oversampling_mode = PTS_MODE_LOW_POWER;
      wr(PTS_INACTIVITY_OFFSET, 8'h01);
      auto_sleep_enable = 1'b1;
      fev(4'h1); // Restarts the inactivity count from here
      n = 0;
      while (sleeping !== 1'b1 && n < 1500)
      begin
         tick(1);
         n++;
      end
      chk("sleep_delay", 1'b1, n + 4 >= 256 * BU && n <= 256 * BU + 4);
      chk("sleep_transition_event", 1'b1, sleep_transition_event);
      tick(1);
      chk("active_rate_select", 3'h6, active_rate_select);
      chk("active_oversampling_mode", PTS_MODE_LOW_POWER, active_oversampling_mode);
      fev(4'h1);
      chk("sleeping", 1'b1, sleeping);
      fev(4'h4);
      chk("sleeping", 1'b1, sleeping);
      data_ready_event = 1'b1;
      tick(1);
      data_ready_event = 1'b0;
      chk("sleeping", 1'b1, sleeping);
      interrupt_enable = 4'hf;
      fev(4'h4);
      chk("sleeping", 1'b0, sleeping);
      chk("sleep_transition_event", 1'b1, sleep_transition_event);
      tick(1);
      chk("active_rate_select", 3'h0, active_rate_select);
      tick(700);
      fev(4'h2);
      tick(700);
      chk("sleeping", 1'b0, sleeping);
      auto_sleep_enable = 1'b0;
      tick(1500);
      chk("sleeping", 1'b0, sleeping);
      // Slowest wake rate doubles the inactivity step
      wake_data_rate_select = PTS_RATE_SLOWEST;
      sleep_sample_rate = 2'h3;
      auto_sleep_enable = 1'b1;
      fev(4'h1);
      n = 0;
      while (sleeping !== 1'b1 && n < 2500)
      begin
         tick(1);
         n++;
      end
      chk("slow_sleep_delay", 1'b1, n + 4 >= 512 * BU && n <= 512 * BU + 4);
      tick(1);
      chk("active_rate_select", 3'h7, active_rate_select);
   endtask
   // ==========================================================
   // Verdict, clock, watchdog and main sequence
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // Run needs about 9200 cycles; twice that means a hang
   initial
   begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      print_verdict();
   end
   initial
   begin
      {reset, reg_write_enable, active, auto_sleep_enable, pulse_lowpass_enable} = 5'h10;
      {double_pulse_enable, sleep_interrupt_enable, data_ready_event} = 3'h2;
      {pulse_start, pulse_valid_end, pulse_too_long} = 3'h0;
      {reg_address, reg_write_data, wake_data_rate_select, sleep_sample_rate} = 21'h0;
      {wake_oversampling_mode, sleep_oversampling_mode} = 4'h0;
      {interrupt_enable, wake_source_enable, function_event} = 12'h0;
      tick(2);
      reset = 1'b0;
      t_regs();
      active = 1'b1;
      t_latency(3'h0, PTS_MODE_NORMAL, 1'b1, 2);
      t_latency(3'h3, PTS_MODE_HIGH_RES, 1'b0, 1);
      t_latency(3'h5, PTS_MODE_LOW_NOISE, 1'b1, 128);
      t_latency(3'h7, PTS_MODE_LOW_POWER, 1'b1, 256);
      t_double();
      t_sleep();
      print_verdict();
   end
endmodule // pts_timing_bench
